// *** shared/fes_pkg.sv ***
// package: constants and types of the flash erase sequencer
package fes_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int WINDOW_US    = 100;
  localparam int WINDOW_CYC   = WINDOW_US * CLK_MHZ;
  localparam int SUSP_MIN_NS  = 100;
  localparam int SUSP_CYC     = (SUSP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMER_W      = 16;

  // ---------------------------------------------------------------
  // command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1   = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2   = 8'h55;
  localparam logic [7:0] CMD_ERASE_SET = 8'h80;
  localparam logic [7:0] CMD_BULK      = 8'h10;
  localparam logic [7:0] CMD_SECTOR    = 8'h30;
  localparam logic [7:0] CMD_SUSPEND   = 8'hB0;
  localparam logic [7:0] CMD_RESUME    = 8'h30;
  localparam logic [7:0] CMD_RESET     = 8'hF0;
  localparam logic [2:0] SEQ_LAST      = 3'h5;

  // ---------------------------------------------------------------
  // status byte fields and read values
  // ---------------------------------------------------------------
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT   = 5;
  localparam int WINDOW_BIT = 3;
  localparam int LOCK_BIT   = 7;
  localparam logic [7:0] INVALID_DATA = 8'h00;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_READ     = 8'h01,
    ST_SEQ      = 8'h02,
    ST_WINDOW   = 8'h04,
    ST_ERASE    = 8'h08,
    ST_SUSPWAIT = 8'h10,
    ST_SUSP     = 8'h20,
    ST_BULK     = 8'h40,
    ST_FAIL     = 8'h80
  } fes_state_type;

  typedef struct packed {
    logic       preprog;
    logic       erase;
    logic       hold;
    logic [7:0] mask;
  } fes_array_type;

  typedef struct packed {
    fes_state_type        st;
    logic [2:0]           step;
    logic                 bulk;
    logic                 started;
    logic                 pre;
    logic [7:0]           mask;
    logic [TIMER_W-1:0]   timer;
    logic                 tog;
    logic                 fail;
    logic [7:0]           rdata;
    logic                 rvalid;
  } fes_regs_type;

endpackage

// *** hdl/fes_sequencer.sv ***
// flash erase sequencer: command decode, erase control, status reads
`timescale 1ns/1ps
`default_nettype none

module fes_sequencer
  import fes_pkg::*;
#(
  parameter int WINDOW_CYCLES = WINDOW_CYC
) (
  input  wire logic          clk,            // 100 MHz clock
  input  wire logic          sys_rst,        // sync reset, active high
  input  wire logic          wr_strobe,      // host write, one cycle
  input  wire logic          rd_strobe,      // host array read, one cycle
  input  wire logic [7:0]    wr_data,        // host write byte
  input  wire logic [7:0]    sector_selects, // one-hot sector decode
  input  wire logic          prot_rd,        // read protection register
  input  wire logic          lock_rd,        // read lock status register
  input  wire logic [7:0]    prot_bits,      // protection from test port
  input  wire logic          lock_bit,       // content lock from test port
  input  wire logic [7:0]    array_rdata,    // array read byte
  input  wire logic          array_done,     // array phase done, pulse
  input  wire logic          array_fail,     // cycles exhausted at done
  output var fes_array_type  array_ctl,      // array operation control
  output logic [7:0]         rd_data,        // read answer
  output logic               rd_valid        // read answer valid
);

  fes_regs_type r_reg;
  fes_regs_type r_next;

  logic [7:0] addr_sel;
  logic       in_target;
  logic       busy;
  logic [7:0] status;
  logic [7:0] live_mask;

  // ---------------------------------------------------------------
  // read-side helpers
  // ---------------------------------------------------------------
  assign addr_sel  = sector_selects;
  assign live_mask = r_reg.mask & ~prot_bits;
  assign in_target = |(addr_sel & r_reg.mask);
  assign busy      = (r_reg.st == ST_WINDOW)
                  || (r_reg.st == ST_ERASE)
                  || (r_reg.st == ST_SUSPWAIT)
                  || (r_reg.st == ST_BULK)
                  || (r_reg.st == ST_FAIL);

  always_comb begin
    status             = ZERO_BYTE;
    status[POLL_BIT]   = 1'b0;
    status[TOGGLE_BIT] = r_reg.tog;
    status[FAIL_BIT]   = r_reg.fail;
    status[WINDOW_BIT] = (r_reg.st != ST_WINDOW);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    r_next        = r_reg;
    r_next.rvalid = 1'b0;

    // read answers
    if (prot_rd) begin
      r_next.rdata  = prot_bits;
      r_next.rvalid = 1'b1;
    end else if (lock_rd) begin
      r_next.rdata           = ZERO_BYTE;
      r_next.rdata[LOCK_BIT] = lock_bit;
      r_next.rvalid          = 1'b1;
    end else if (rd_strobe) begin
      r_next.rvalid = 1'b1;
      if (busy && (r_reg.bulk || in_target)) begin
        r_next.rdata = status;
        if (r_reg.st != ST_FAIL)
          r_next.tog = ~r_reg.tog;
      end else if (r_reg.st == ST_SUSP && in_target) begin
        r_next.rdata = INVALID_DATA;
      end else begin
        r_next.rdata = array_rdata;
      end
    end

    case (r_reg.st)
      ST_READ: begin
        r_next.step = 3'h0;
        if (wr_strobe && wr_data == CMD_UNLOCK1) begin
          r_next.st   = ST_SEQ;
          r_next.step = 3'h1;
        end
      end

      ST_SEQ: begin
        if (wr_strobe) begin
          r_next.step = r_reg.step + 3'h1;
          case (r_reg.step)
            3'h1, 3'h4: begin
              if (wr_data != CMD_UNLOCK2)
                r_next.st = ST_READ;
            end
            3'h2: begin
              if (wr_data != CMD_ERASE_SET)
                r_next.st = ST_READ;
            end
            3'h3: begin
              if (wr_data != CMD_UNLOCK1)
                r_next.st = ST_READ;
            end
            SEQ_LAST: begin
              r_next.pre     = 1'b1;
              r_next.started = 1'b0;
              r_next.fail    = 1'b0;
              if (wr_data == CMD_BULK) begin
                r_next.bulk = 1'b1;
                r_next.mask = ~prot_bits;
                r_next.st   = ST_BULK;
              end else if (wr_data == CMD_SECTOR) begin
                r_next.bulk  = 1'b0;
                r_next.mask  = addr_sel;
                r_next.timer = '0;
                r_next.st    = ST_WINDOW;
              end else begin
                r_next.st = ST_READ;
              end
            end
            default: r_next.st = ST_READ;
          endcase
        end
      end

      ST_WINDOW: begin
        r_next.timer = r_reg.timer + 1'b1;
        if (wr_strobe) begin
          if (wr_data == CMD_SECTOR) begin
            r_next.mask  = r_reg.mask | addr_sel;
            r_next.timer = '0;
          end else if (wr_data == CMD_SUSPEND) begin
            r_next.timer = '0;
            r_next.st    = ST_SUSPWAIT;
          end else begin
            r_next.mask = 8'h00;
            r_next.st   = ST_READ;
          end
        end else if (r_reg.timer >= TIMER_W'(WINDOW_CYCLES - 1)) begin
          if (live_mask == 8'h00) begin
            r_next.st = ST_READ;
          end else begin
            r_next.mask = live_mask;
            r_next.st   = ST_ERASE;
          end
        end
      end

      ST_ERASE: begin
        r_next.started = 1'b1;
        if (wr_strobe && wr_data == CMD_RESET) begin
          r_next.mask = 8'h00;
          r_next.st   = ST_READ;
        end else if (wr_strobe && wr_data == CMD_SUSPEND) begin
          r_next.timer = '0;
          r_next.st    = ST_SUSPWAIT;
        end else if (array_done) begin
          if (array_fail) begin
            r_next.fail = 1'b1;
            r_next.st   = ST_FAIL;
          end else if (r_reg.pre) begin
            r_next.pre = 1'b0;
          end else begin
            r_next.mask = 8'h00;
            r_next.st   = ST_READ;
          end
        end
      end

      ST_SUSPWAIT: begin
        r_next.timer = r_reg.timer + 1'b1;
        if (r_reg.timer >= TIMER_W'(SUSP_CYC - 1))
          r_next.st = ST_SUSP;
      end

      ST_SUSP: begin
        if (wr_strobe && wr_data == CMD_RESUME) begin
          r_next.st = ST_ERASE;
        end else if (wr_strobe && wr_data == CMD_RESET) begin
          r_next.mask = 8'h00;
          r_next.st   = ST_READ;
        end
      end

      ST_BULK: begin
        r_next.mask = ~prot_bits;
        if (array_done) begin
          if (array_fail) begin
            r_next.fail = 1'b1;
            r_next.st   = ST_FAIL;
          end else if (r_reg.pre) begin
            r_next.pre = 1'b0;
          end else begin
            r_next.bulk = 1'b0;
            r_next.mask = 8'h00;
            r_next.st   = ST_READ;
          end
        end
      end

      ST_FAIL: begin
        if (wr_strobe && wr_data == CMD_RESET) begin
          r_next.fail = 1'b0;
          r_next.bulk = 1'b0;
          r_next.mask = 8'h00;
          r_next.st   = ST_READ;
        end
      end

      default: r_next.st = ST_READ;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_reg.st      <= ST_READ;
      r_reg.step    <= 3'h0;
      r_reg.bulk    <= 1'b0;
      r_reg.started <= 1'b0;
      r_reg.pre     <= 1'b0;
      r_reg.mask    <= 8'h00;
      r_reg.timer   <= '0;
      r_reg.tog     <= 1'b0;
      r_reg.fail    <= 1'b0;
      r_reg.rdata   <= 8'h00;
      r_reg.rvalid  <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    array_ctl.preprog = ((r_reg.st == ST_ERASE) || (r_reg.st == ST_BULK))
                        && r_reg.pre;
    array_ctl.erase   = ((r_reg.st == ST_ERASE) || (r_reg.st == ST_BULK))
                        && !r_reg.pre;
    array_ctl.hold    = (r_reg.st == ST_SUSPWAIT)
                     || (r_reg.st == ST_SUSP);
    array_ctl.mask    = (r_reg.st == ST_WINDOW) ? 8'h00 : r_reg.mask;
  end

  assign rd_data  = r_reg.rdata;
  assign rd_valid = r_reg.rvalid;

endmodule

`default_nettype wire

// *** tb/fes_sequencer_monitor.sv ***
// checker: port-level properties of the flash erase sequencer
`timescale 1ns/1ps
`default_nettype none
module fes_sequencer_monitor
  import fes_pkg::*;
(
  input wire logic          clk,            // clock
  input wire logic          sys_rst,        // reset
  input wire logic          wr_strobe,      // write
  input wire logic          rd_strobe,      // read
  input wire logic [7:0]    wr_data,        // byte
  input wire logic [7:0]    sector_selects, // sectors
  input wire logic          prot_rd,        // prot read
  input wire logic          lock_rd,        // lock read
  input wire logic [7:0]    prot_bits,      // prot bits
  input wire logic          lock_bit,       // lock bit
  input wire fes_array_type array_ctl,      // array ctl
  input wire logic [7:0]    rd_data,        // answer
  input wire logic          rd_valid        // valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_answer; (rd_strobe || prot_rd || lock_rd) |=> rd_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_quiet; !(rd_strobe || prot_rd || lock_rd) |=> !rd_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("spurious valid");
  property p_prot; prot_rd |=> rd_data == $past(prot_bits); endproperty
  a_prot: assert property (p_prot) else $error("prot read");
  property p_lock; lock_rd && !prot_rd |=> rd_data == {$past(lock_bit), 7'h00};
  endproperty
  a_lock: assert property (p_lock) else $error("lock read");
  property p_skip; (array_ctl.preprog || array_ctl.erase) |->
    (array_ctl.mask & prot_bits) == 8'h00; endproperty
  a_skip: assert property (p_skip) else $error("protected hit");
  property p_pre; $rose(array_ctl.erase) |->
    ($past(array_ctl.preprog) || $past(array_ctl.hold));
  endproperty
  a_pre: assert property (p_pre) else $error("no preprogram");
  property p_susp; $rose(array_ctl.hold) |->
    $past(wr_strobe && wr_data == CMD_SUSPEND); endproperty
  a_susp: assert property (p_susp) else $error("bad suspend");
  property p_resume; $fell(array_ctl.hold) |-> $past(wr_strobe) &&
    ($past(wr_data) == CMD_RESUME || $past(wr_data) == CMD_RESET); endproperty
  a_resume: assert property (p_resume) else $error("bad resume");
  property p_poll; rd_strobe && !prot_rd && !lock_rd && !array_ctl.hold &&
    (array_ctl.preprog || array_ctl.erase) &&
    (sector_selects & array_ctl.mask) != 8'h00 |=> !rd_data[POLL_BIT];
  endproperty
  a_poll: assert property (p_poll) else $error("poll flag");
endmodule
bind fes_sequencer fes_sequencer_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data),
  .sector_selects(sector_selects), .prot_rd(prot_rd), .lock_rd(lock_rd),
  .prot_bits(prot_bits), .lock_bit(lock_bit), .array_ctl(array_ctl),
  .rd_data(rd_data), .rd_valid(rd_valid));
`default_nettype wire

// *** tb/fes_array_model.sv ***
// partner: flash array phase timing model
`timescale 1ns/1ps
`default_nettype none
module fes_array_model
  import fes_pkg::*;
#(
  parameter int DELAY = 30
) (
  input  wire logic          clk,        // clock
  input  wire logic          sys_rst,    // reset
  input  wire fes_array_type array_ctl,  // phase request
  input  wire logic          fail_en,    // fail erase
  output logic               array_done, // done pulse
  output logic               array_fail  // exhausted
);
  int cnt;
  wire logic busy = (array_ctl.preprog || array_ctl.erase) && !array_ctl.hold;
  always_ff @(posedge clk) begin
    if (sys_rst || !busy || array_done) begin
      cnt <= 0;
      array_done <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      array_done <= (cnt == DELAY - 1);
    end
  end
  assign array_fail = array_done && fail_en && array_ctl.erase;
endmodule
`default_nettype wire

// *** tb/tb_flash_erase_sequencer.sv ***
// testbench: flash erase sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_flash_erase_sequencer;
  import fes_pkg::*;
  localparam int WIN = 20;
  logic clk, sys_rst, wr_strobe, rd_strobe, prot_rd, lock_rd, lock_bit;
  logic array_done, array_fail, rd_valid, fail_en;
  logic [7:0] wr_data, sector_selects, prot_bits, array_rdata, rd_data;
  logic [7:0] exp_q[$], msk_q[$], e_v, m_v;
  fes_array_type array_ctl;
  int error_cnt, n_compared;
  fes_sequencer #(.WINDOW_CYCLES(WIN)) DUT (.clk(clk), .sys_rst(sys_rst),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data),
    .sector_selects(sector_selects), .prot_rd(prot_rd), .lock_rd(lock_rd),
    .prot_bits(prot_bits), .lock_bit(lock_bit), .array_rdata(array_rdata),
    .array_done(array_done), .array_fail(array_fail),
    .array_ctl(array_ctl), .rd_data(rd_data), .rd_valid(rd_valid));
  fes_array_model u_arr (.clk(clk), .sys_rst(sys_rst), .array_ctl(array_ctl),
    .fail_en(fail_en), .array_done(array_done), .array_fail(array_fail));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] flags();
    return {5'h00, array_ctl.preprog, array_ctl.erase, array_ctl.hold};
  endfunction
  always @(negedge clk) if (rd_valid === 1'b1) begin
    e_v = exp_q.pop_front();
    m_v = msk_q.pop_front();
    check(rd_data & m_v, e_v & m_v);
  end
  task automatic wr(input logic [7:0] b, input logic [7:0] s);
    @(posedge clk); #1;
    wr_strobe = 1'b1;
    wr_data = b;
    sector_selects = s;
    @(posedge clk); #1;
    wr_strobe = 1'b0;
  endtask
  // kind: 0 status, 1 protection, 2 lock, 3 array data
  task automatic rd(input logic [1:0] k, input logic [7:0] s, e, m);
    @(posedge clk); #1;
    {prot_rd, lock_rd, rd_strobe} = {k == 2'h1, k == 2'h2, k[0] == k[1]};
    sector_selects = s;
    array_rdata = 8'($urandom);
    exp_q.push_back(k == 2'h3 ? array_rdata : e);
    msk_q.push_back(m);
    @(posedge clk); #1;
    {prot_rd, lock_rd, rd_strobe} = 3'h0;
  endtask
  task automatic seq(input logic [7:0] last, input logic [7:0] s);
    wr(CMD_UNLOCK1, s);
    wr(CMD_UNLOCK2, s);
    wr(CMD_ERASE_SET, s);
    wr(CMD_UNLOCK1, s);
    wr(CMD_UNLOCK2, s);
    wr(last, s);
  endtask
  task automatic wait_ctl(input int b, input logic lvl);
    for (int i = 0; i < 400 && array_ctl[b] !== lvl; i++) @(posedge clk);
    #1;
    check({7'h00, array_ctl[b]}, {7'h00, lvl});
  endtask
  initial begin
    #100000;
    error_cnt++;
    test_done;
  end
  initial begin
    {wr_strobe, rd_strobe, prot_rd, lock_rd, fail_en, lock_bit} = 6'h00;
    {wr_data, sector_selects, array_rdata, prot_bits} = 32'h00000000;
    sys_rst = 1'b1;
    void'($urandom(38235));
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) begin
      prot_bits = 8'($urandom);
      lock_bit = 1'($urandom);
      rd(2'h1, 8'h01, prot_bits, 8'hFF);
      rd(2'h2, 8'h01, {lock_bit, 7'h00}, 8'hFF);
    end
    prot_bits = 8'h04;
    seq(8'h11, 8'h01);
    wr(CMD_BULK, 8'h01);
    check(flags(), 8'h00);
    rd(2'h3, 8'h01, 8'h00, 8'hFF);
    seq(CMD_SECTOR, 8'h01);
    rd(2'h0, 8'h01, 8'h00, 8'hBF);
    repeat (10) @(posedge clk);
    wr(CMD_SECTOR, 8'h04);
    repeat (15) @(posedge clk);
    wr(CMD_SECTOR, 8'h08);
    repeat (15) @(posedge clk);
    #1;
    check(flags(), 8'h00);
    wait_ctl(10, 1'b1);
    check(array_ctl.mask, 8'h09);
    rd(2'h0, 8'h01, 8'h08, 8'hBF);
    wr(CMD_ERASE_SET, 8'h01);
    check(flags(), 8'h04);
    wr(CMD_SUSPEND, 8'h01);
    check(flags(), 8'h01);
    repeat (SUSP_CYC + 2) @(posedge clk);
    rd(2'h0, 8'h01, INVALID_DATA, 8'hFF);
    rd(2'h3, 8'h02, 8'h00, 8'hFF);
    wr(CMD_ERASE_SET, 8'h02);
    check(flags(), 8'h01);
    wr(CMD_RESUME, 8'h01);
    check(flags(), 8'h04);
    wait_ctl(10, 1'b0);
    wait_ctl(9, 1'b0);
    rd(2'h3, 8'h01, 8'h00, 8'hFF);
    seq(CMD_SECTOR, 8'h02);
    wr(CMD_ERASE_SET, 8'h02);
    repeat (WIN + 5) @(posedge clk);
    #1;
    check(flags(), 8'h00);
    seq(CMD_SECTOR, 8'h02);
    wait_ctl(10, 1'b1);
    wr(CMD_RESET, 8'h02);
    check(flags(), 8'h00);
    prot_bits = 8'h00;
    seq(CMD_BULK, 8'h20);
    wait_ctl(10, 1'b1);
    check(array_ctl.mask, 8'hFF);
    wr(CMD_RESET, 8'h20);
    check(flags(), 8'h04);
    fail_en = 1'b1;
    wait_ctl(9, 1'b1);
    wait_ctl(9, 1'b0);
    rd(2'h0, 8'h01, 8'h28, 8'hBF);
    wr(CMD_RESET, 8'h01);
    rd(2'h3, 8'h01, 8'h00, 8'hFF);
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule
`default_nettype wire
